// ### core/hio_pkg.sv
/*
 * hio_pkg: register map, field positions, reset values and timing
 * constants for the host interrupt output stage.
 * Assumes a single 25 MHz device clock shared by every user.
 */
package hio_pkg;

	// ========================================
	// register offsets
	localparam logic [7:0] OFS_ID = 8'h50;
	localparam logic [7:0] OFS_CFG = 8'h54;
	localparam logic [7:0] OFS_STS = 8'h58;
	localparam logic [7:0] OFS_EN = 8'h5C;

	// ========================================
	// config field positions and power event status bit
	localparam int CFG_INTERVAL_LSB = 24;
	localparam int CFG_RESTART_BIT = 14;
	localparam int CFG_ACTIVE_BIT = 13;
	localparam int CFG_LINE_BIT = 12;
	localparam int CFG_PIN_EN_BIT = 8;
	localparam int CFG_POL_BIT = 4;
	localparam int CFG_TYPE_BIT = 0;
	localparam int POWER_EVENT_BIT = 17;

	// ========================================
	// reset values
	localparam logic [31:0] RST_STS = 32'h0000_0000;
	localparam logic [31:0] RST_EN = 32'h0000_0000;
	localparam logic [7:0] RST_INTERVAL = 8'h00;
	localparam logic RST_POL = 1'b0;
	localparam logic RST_TYPE = 1'b0;

	// ========================================
	// timing
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int HOLDOFF_UNIT_NS = 10000;
	localparam int TICK_CYCLES = HOLDOFF_UNIT_NS / CLOCK_PERIOD_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

	// ========================================
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} hio_req_t;

	// ========================================
	// whole block state
	typedef struct packed {
		logic [31:0] sts;
		logic [31:0] en;
		logic [7:0] interval;
		logic pin_en;
		logic pol;
		logic buf_type;
		logic active;
		logic [7:0] units;
		logic [7:0] pre;
		logic asserted;
		logic prev_asserted;
		logic [31:0] rdata;
	} hio_state_t;

endpackage

// ### core/hio_irq_out.sv
/*
 * hio_irq_out: interrupt status/enable, hold-off timer and request pin
 * driver of a host-attached controller, with its four host registers.
 * Assumes host strobes and event pulses come from the same clock domain.
 */
// Behaviour
// - pin held off for interval field bits 31:24 times 10 us.
// - zero interval disables hold-off, clears counter, delivers pending.
// - a new non-zero interval governs every later interrupt.
// - power event interrupt bypasses hold-off entirely.
// - writing one to bit 14 restarts the hold-off interval.
// - bit 13 reads one while hold-off withholds interrupts.
// - bit 12 shows internal combined line regardless of pin enable, hold-off.
// - bit 8 clear keeps pin deasserted; status bits unaffected.
// - bit 4 picks push-pull polarity: zero low, one high.
// - bit 0 zero open-drain active low, one push-pull.
// - polarity and buffer type survive software reset.
// - identity register gives design code high, revision low.
// - config 54h, status 58h, enable 5Ch, all reset zero.
`timescale 1ns/1ps
module hio_irq_out #(
	parameter logic [15:0] DESIGN_CODE = 16'hA5C3, // arbitrary value
	parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic soft_rst,
	// host register port
	input wire hio_pkg::hio_req_t req,
	output logic [31:0] rdata,
	// interrupt sources, one-cycle pulses
	input wire logic [31:0] events,
	// request pin
	output logic irq_out,
	output logic irq_oe
);

	// ========================================
	// elaboration check
	if (hio_pkg::TICK_CYCLES < 1 || hio_pkg::TICK_CYCLES > 256) begin
		$error("hold-off tick count out of range");
	end

	hio_pkg::hio_state_t s_q;
	hio_pkg::hio_state_t s_d;
	logic line;
	logic power_on;
	logic wr_cfg;
	logic tick;
	logic fall_start;
	logic [31:0] cfg_view;

	// ========================================
	// combined line and config view
	assign line = |(s_q.sts & s_q.en);
	assign power_on = s_q.sts[hio_pkg::POWER_EVENT_BIT] &
		s_q.en[hio_pkg::POWER_EVENT_BIT];
	assign wr_cfg = req.wr && req.addr == hio_pkg::OFS_CFG;
	assign tick = s_q.pre == hio_pkg::TICK_LAST;
	// pin just fell: hold-off begins, pin kept low this cycle too
	assign fall_start = s_q.prev_asserted && !s_q.asserted &&
		s_q.interval != 8'h00;
	assign cfg_view = {s_q.interval, 9'h000, 1'b0, s_q.active, line,
		3'h0, s_q.pin_en, 3'h0, s_q.pol, 3'h0, s_q.buf_type};

	// ========================================
	// next state
	always_comb begin
		s_d = s_q;
		// status: hardware set wins over write-one clear
		if (req.wr && req.addr == hio_pkg::OFS_STS) begin
			s_d.sts = s_q.sts & ~req.wdata;
		end
		s_d.sts = s_d.sts | events;
		if (req.wr && req.addr == hio_pkg::OFS_EN) begin
			s_d.en = req.wdata;
		end
		if (wr_cfg) begin
			s_d.interval = req.wdata[hio_pkg::CFG_INTERVAL_LSB +: 8];
			s_d.pin_en = req.wdata[hio_pkg::CFG_PIN_EN_BIT];
			s_d.pol = req.wdata[hio_pkg::CFG_POL_BIT];
			s_d.buf_type = req.wdata[hio_pkg::CFG_TYPE_BIT];
		end
		// hold-off timer
		if (s_q.active) begin
			s_d.pre = tick ? 8'h00 : s_q.pre + 8'h01;
			if (tick) begin
				s_d.units = s_q.units + 8'h01;
				if (s_q.units + 8'h01 >= s_q.interval) begin
					s_d.active = 1'b0;
					s_d.units = 8'h00;
				end
			end
		end
		if (fall_start) begin
			s_d.active = 1'b1;
			s_d.units = 8'h00;
			s_d.pre = 8'h00;
		end
		if (wr_cfg && req.wdata[hio_pkg::CFG_RESTART_BIT]) begin
			s_d.active = 1'b1;
			s_d.units = 8'h00;
			s_d.pre = 8'h00;
		end
		if (s_d.interval == 8'h00) begin
			s_d.active = 1'b0;
			s_d.units = 8'h00;
			s_d.pre = 8'h00;
		end
		// pin level; new interval applies from here on
		s_d.asserted = s_q.pin_en &&
			((line && !s_q.active && !fall_start) || power_on);
		s_d.prev_asserted = s_q.asserted;
		// read data
		if (req.rd) begin
			if (req.addr == hio_pkg::OFS_ID) begin
				s_d.rdata = {DESIGN_CODE, REVISION};
			end else if (req.addr == hio_pkg::OFS_CFG) begin
				s_d.rdata = cfg_view;
			end else if (req.addr == hio_pkg::OFS_STS) begin
				s_d.rdata = s_q.sts;
			end else if (req.addr == hio_pkg::OFS_EN) begin
				s_d.rdata = s_q.en;
			end else begin
				s_d.rdata = 32'h0000_0000;
			end
		end
		// software reset keeps polarity and buffer type
		if (soft_rst) begin
			s_d = '0;
			s_d.pol = s_q.pol;
			s_d.buf_type = s_q.buf_type;
		end
	end

	// ========================================
	// state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.sts <= hio_pkg::RST_STS;
			s_q.en <= hio_pkg::RST_EN;
			s_q.interval <= hio_pkg::RST_INTERVAL;
			s_q.pol <= hio_pkg::RST_POL;
			s_q.buf_type <= hio_pkg::RST_TYPE;
		end else begin
			s_q <= s_d;
		end
	end

	// ========================================
	// pin driver
	assign rdata = s_q.rdata;
	assign irq_out = s_q.buf_type ? (s_q.asserted == s_q.pol) : 1'b0;
	assign irq_oe = s_q.buf_type ? 1'b1 : s_q.asserted;

	// ========================================
	// assertions
	sequence s_restart;
		wr_cfg && req.wdata[hio_pkg::CFG_RESTART_BIT] &&
			req.wdata[31:24] != 8'h00 && !soft_rst;
	endsequence

	sequence s_fresh;
		s_q.active && s_q.units == 8'h00 && s_q.pre == 8'h00;
	endsequence

	property p_holdoff_blocks;
		@(posedge clock) disable iff (rst)
		s_q.active && !power_on && !soft_rst |=> !s_q.asserted;
	endproperty
	a_holdoff_blocks: assert property (p_holdoff_blocks)
		else $error("pin asserted during hold-off");

	property p_zero_disables;
		@(posedge clock) disable iff (rst)
		s_q.interval == 8'h00 |-> !s_q.active && s_q.units == 8'h00;
	endproperty
	a_zero_disables: assert property (p_zero_disables)
		else $error("hold-off active with zero interval");

	property p_fall_starts;
		@(posedge clock) disable iff (rst)
		$fell(s_q.asserted) && s_q.interval != 8'h00 && !soft_rst && !wr_cfg
			|=> s_fresh;
	endproperty
	a_fall_starts: assert property (p_fall_starts)
		else $error("no hold-off after pin deassertion");

	property p_power_bypass;
		@(posedge clock) disable iff (rst)
		power_on && s_q.pin_en && !soft_rst |=> s_q.asserted;
	endproperty
	a_power_bypass: assert property (p_power_bypass)
		else $error("power event delayed");

	property p_restart;
		@(posedge clock) disable iff (rst)
		s_restart |=> s_fresh;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not begin a fresh interval");

	property p_status_read;
		@(posedge clock) disable iff (rst)
		req.rd && req.addr == hio_pkg::OFS_CFG && !soft_rst
			|=> rdata[13] == $past(s_q.active) && rdata[12] == $past(line);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("config read shows wrong status");

	property p_pin_off;
		@(posedge clock) disable iff (rst)
		!s_q.pin_en |=> !s_q.asserted;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("pin asserted while disabled");

	property p_push_pull;
		@(posedge clock) disable iff (rst)
		s_q.buf_type |-> irq_oe && irq_out == (s_q.asserted == s_q.pol);
	endproperty
	a_push_pull: assert property (p_push_pull)
		else $error("push-pull level wrong");

	property p_open_drain;
		@(posedge clock) disable iff (rst)
		!s_q.buf_type |-> !irq_out && irq_oe == s_q.asserted;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain drive wrong");

	property p_soft_keep;
		@(posedge clock) disable iff (rst)
		soft_rst |=> s_q.pol == $past(s_q.pol) &&
			s_q.buf_type == $past(s_q.buf_type) && s_q.en == 32'h0000_0000;
	endproperty
	a_soft_keep: assert property (p_soft_keep)
		else $error("software reset disturbed pin setup");

	property p_id_read;
		@(posedge clock) disable iff (rst)
		req.rd && req.addr == hio_pkg::OFS_ID && !soft_rst
			|=> rdata == {DESIGN_CODE, REVISION};
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("identity read wrong");

	property p_expiry;
		@(posedge clock) disable iff (rst)
		s_q.active && tick && s_q.units + 8'h01 >= s_q.interval &&
			!soft_rst && !wr_cfg && !$fell(s_q.asserted)
			|=> !s_q.active;
	endproperty
	a_expiry: assert property (p_expiry)
		else $error("hold-off did not expire");

endmodule

// ### verification/hio_host_model.sv
/*
 * hio_host_model: host end of the request pin, with the wire's pull-up.
 * Assumes the device drives out and oe from registers on one clock.
 */
`timescale 1ns/1ps
module hio_host_model (
	// pin from device
	input wire logic irq_out,
	input wire logic irq_oe,
	// level on the wire
	output logic pin_level
);
	// ========================================
	// released wire rises through the pull-up
	assign pin_level = irq_oe ? irq_out : 1'b1;
endmodule

// ### verification/host_interrupt_output_control_tb_top.sv
/*
 * testbench for hio_irq_out: register port, events and the pin level.
 * Assumes hio_host_model resolves the pin and a 40 ns clock.
 */
`timescale 1ns/1ps
module host_interrupt_output_control_tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic soft_rst = 1'b0;
	hio_pkg::hio_req_t req = '0;
	logic [31:0] rdata;
	logic [31:0] events = 32'h0000_0000;
	logic irq_out;
	logic irq_oe;
	logic pin_level;
	int n_errors = 0;
	int cmp_count = 0;

	hio_irq_out hio_irq_out_i (.clock(clock), .rst(rst),
		.soft_rst(soft_rst), .req(req), .rdata(rdata), .events(events),
		.irq_out(irq_out), .irq_oe(irq_oe));
	hio_host_model hio_host_model_i (.irq_out(irq_out), .irq_oe(irq_oe),
		.pin_level(pin_level));

	// ========================================
	// helpers
	initial begin
		forever #20 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		#1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		step(1);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		#1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		step(1);
		req.rd = 1'b0;
		step(1);
		check(rdata, exp);
	endtask
	task automatic pulse(input logic [31:0] e);
		@(posedge clock);
		#1 events = e;
		step(1);
		events = 32'h0000_0000;
	endtask
	task automatic pin(input logic exp);
		check({31'h0, pin_level}, {31'h0, exp});
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ========================================
	// scenarios
	task automatic t_map;
		wr(hio_pkg::OFS_ID, 32'hFFFF_FFFF);
		rd(hio_pkg::OFS_ID, 32'hA5C3_0001);
		rd(hio_pkg::OFS_CFG, 32'h0000_0000);
		rd(hio_pkg::OFS_STS, 32'h0000_0000);
		rd(hio_pkg::OFS_EN, 32'h0000_0000);
		rd(8'h60, 32'h0000_0000);
		pin(1'b1);
		$display("test map done");
	endtask
	task automatic t_pin;
		wr(hio_pkg::OFS_EN, 32'h0002_0001);
		wr(hio_pkg::OFS_CFG, 32'h0000_0111);
		pulse(32'h0000_0001);
		step(2);
		pin(1'b1);
		rd(hio_pkg::OFS_CFG, 32'h0000_1111);
		wr(hio_pkg::OFS_CFG, 32'h0000_0101);
		step(2);
		pin(1'b0);
		wr(hio_pkg::OFS_CFG, 32'h0000_0110);
		step(2);
		pin(1'b0);
		wr(hio_pkg::OFS_CFG, 32'h0000_0011);
		step(2);
		pin(1'b0);
		rd(hio_pkg::OFS_STS, 32'h0000_0001);
		rd(hio_pkg::OFS_CFG, 32'h0000_1011);
		$display("test pin done");
	endtask
	task automatic t_hold;
		wr(hio_pkg::OFS_CFG, 32'h0100_0111);
		step(2);
		pin(1'b1);
		wr(hio_pkg::OFS_STS, 32'h0000_0001);
		step(3);
		pin(1'b0);
		pulse(32'h0000_0001);
		step(2);
		pin(1'b0);
		rd(hio_pkg::OFS_CFG, 32'h0100_3111);
		pulse(32'h0002_0000);
		step(2);
		pin(1'b1);
		wr(hio_pkg::OFS_CFG, 32'h0000_0111);
		wr(hio_pkg::OFS_STS, 32'h0002_0000);
		step(3);
		pin(1'b1);
		wr(hio_pkg::OFS_CFG, 32'h0100_0111);
		wr(hio_pkg::OFS_STS, 32'h0000_0001);
		pulse(32'h0000_0001);
		step(200);
		pin(1'b0);
		step(100);
		pin(1'b1);
		wr(hio_pkg::OFS_CFG, 32'h0100_4111);
		step(2);
		pin(1'b0);
		rd(hio_pkg::OFS_CFG, 32'h0100_3111);
		$display("test hold done");
	endtask
	task automatic t_soft;
		@(posedge clock);
		#1 soft_rst = 1'b1;
		step(1);
		soft_rst = 1'b0;
		rd(hio_pkg::OFS_CFG, 32'h0000_0011);
		rd(hio_pkg::OFS_EN, 32'h0000_0000);
		$display("test soft done");
	endtask

	// ========================================
	// main sequence and watchdog
	initial begin
		step(2);
		rst = 1'b0;
		t_map();
		t_pin();
		t_hold();
		t_soft();
		complete_run();
	end
	initial begin
		#800000;
		n_errors++;
		complete_run();
	end
endmodule
